// ===== hw/dapc_consts.svh
`ifndef DAPC_CONSTS_SVH
`define DAPC_CONSTS_SVH

`define DAPC_DATA_W 14
`define DAPC_ADDR_W 4
`define DAPC_REG_W 32
`define DAPC_NAP_W 8
`define DAPC_MODE_W 3

// register offsets (byte addresses)
`define DAPC_ADDR_CTRL 4'h0
`define DAPC_ADDR_NAP_WAKE 4'h4
`define DAPC_ADDR_STATUS 4'h8

// field positions
`define DAPC_CTRL_PD_BIT 0
`define DAPC_STAT_MODE_A_LSB 0
`define DAPC_STAT_MODE_B_LSB 3
`define DAPC_STAT_LIVE_A_BIT 6
`define DAPC_STAT_LIVE_B_BIT 7

// reset values
`define DAPC_CTRL_RESET 1'h0
`define DAPC_NAP_WAKE_RESET 8'h64

// timing: nap wake in sample clocks, sleep wake in milliseconds
`define DAPC_NAP_WAKE_CYCLES 100
`define DAPC_SLEEP_WAKE_MS 2
`define DAPC_CLK_KHZ 250000
`define DAPC_SLEEP_WAKE_CYCLES (`DAPC_SLEEP_WAKE_MS * `DAPC_CLK_KHZ)

`endif

// ===== hw/dapc_pkg.sv
package dapc_pkg;
  typedef enum logic [2:0] {
    DAPC_RUN,
    DAPC_NAP,
    DAPC_SLEEP,
    DAPC_WAKE_NAP,
    DAPC_WAKE_SLEEP
  } dapc_mode_e;
endpackage

// ===== hw/dapc_chan_power.sv
`include "dapc_consts.svh"

module dapc_chan_power #(
  parameter int SLEEP_CYCLES = `DAPC_SLEEP_WAKE_CYCLES,
  parameter int CNT_W = 20
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sample_tick,
  input wire logic power_down,
  input wire logic output_enable_n,
  input wire logic [`DAPC_NAP_W-1:0] nap_cycles,
  output dapc_pkg::dapc_mode_e mode,
  output logic live,
  output logic drive
);
  generate
    if (SLEEP_CYCLES < 1 || SLEEP_CYCLES >= (1 << CNT_W)) begin : g_bad
      $error("sleep wake count does not fit the counter");
    end
  endgenerate

  logic pd_q;
  logic oen_q;
  logic [`DAPC_NAP_W-1:0] nap_cnt;
  logic [CNT_W-1:0] sleep_cnt;
  dapc_pkg::dapc_mode_e next_mode;
  logic nap_done;
  logic sleep_done;

  // pins are levels taken on the channel's own sample clock
  always_ff @(posedge clk) begin
    if (reset) begin
      pd_q <= 1'b0;
      oen_q <= 1'b0;
    end else if (sample_tick) begin
      pd_q <= power_down;
      oen_q <= output_enable_n;
    end
  end

  assign nap_done = sample_tick &&
    (({1'b0, nap_cnt} + 9'h001) >= {1'b0, nap_cycles});
  assign sleep_done = (sleep_cnt == CNT_W'(SLEEP_CYCLES - 1));

  always_comb begin
    next_mode = mode;
    unique case (mode)
      dapc_pkg::DAPC_RUN: begin
        if (pd_q) next_mode = oen_q ? dapc_pkg::DAPC_SLEEP : dapc_pkg::DAPC_NAP;
      end
      dapc_pkg::DAPC_NAP: begin
        if (!pd_q) next_mode = dapc_pkg::DAPC_WAKE_NAP;
        else if (oen_q) next_mode = dapc_pkg::DAPC_SLEEP;
      end
      dapc_pkg::DAPC_SLEEP: begin
        if (!pd_q) next_mode = dapc_pkg::DAPC_WAKE_SLEEP;
        else if (!oen_q) next_mode = dapc_pkg::DAPC_NAP;
      end
      dapc_pkg::DAPC_WAKE_NAP: begin
        if (pd_q) next_mode = oen_q ? dapc_pkg::DAPC_SLEEP : dapc_pkg::DAPC_NAP;
        else if (nap_done) next_mode = dapc_pkg::DAPC_RUN;
      end
      dapc_pkg::DAPC_WAKE_SLEEP: begin
        if (pd_q) next_mode = oen_q ? dapc_pkg::DAPC_SLEEP : dapc_pkg::DAPC_NAP;
        else if (sleep_done) next_mode = dapc_pkg::DAPC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) mode <= dapc_pkg::DAPC_RUN;
    else mode <= next_mode;
  end

  // nap wake counts sample clocks; sleep wake counts core clocks, since it is a time
  always_ff @(posedge clk) begin
    if (reset || mode != dapc_pkg::DAPC_WAKE_NAP) nap_cnt <= '0;
    else if (sample_tick) nap_cnt <= nap_cnt + 8'h01;
  end

  always_ff @(posedge clk) begin
    if (reset || mode != dapc_pkg::DAPC_WAKE_SLEEP) sleep_cnt <= '0;
    else sleep_cnt <= sleep_cnt + CNT_W'(1);
  end

  assign live = (mode == dapc_pkg::DAPC_RUN);
  assign drive = live && !oen_q;

  AST_SLEEP_ENTRY: assert property (@(posedge clk) disable iff (reset)
    sample_tick && power_down && output_enable_n && mode == dapc_pkg::DAPC_RUN
    |=> ##1 mode == dapc_pkg::DAPC_SLEEP)
    else $error("sleep not entered");

  AST_NAP_ENTRY: assert property (@(posedge clk) disable iff (reset)
    sample_tick && power_down && !output_enable_n && mode == dapc_pkg::DAPC_RUN
    |=> ##1 mode == dapc_pkg::DAPC_NAP)
    else $error("nap not entered");

  AST_RUN_HOLDS: assert property (@(posedge clk) disable iff (reset)
    !pd_q && mode == dapc_pkg::DAPC_RUN |=> mode == dapc_pkg::DAPC_RUN)
    else $error("run left without shutdown");

  AST_SLEEP_WAKE_TIME: assert property (@(posedge clk) disable iff (reset)
    $rose(mode == dapc_pkg::DAPC_RUN) && $past(mode) == dapc_pkg::DAPC_WAKE_SLEEP
    |-> $past(sleep_cnt) == CNT_W'(SLEEP_CYCLES - 1))
    else $error("sleep wake too short");

  AST_NAP_WAKE_TIME: assert property (@(posedge clk) disable iff (reset)
    $rose(mode == dapc_pkg::DAPC_RUN) && $past(mode) == dapc_pkg::DAPC_WAKE_NAP
    |-> ({1'b0, $past(nap_cnt)} + 9'h001) >= {1'b0, nap_cycles})
    else $error("nap wake too short");

  AST_LOW_POWER_QUIET: assert property (@(posedge clk) disable iff (reset)
    mode != dapc_pkg::DAPC_RUN |-> !drive)
    else $error("outputs live while powered down");
endmodule

// ===== hw/dapc_bus_swap.sv
`include "dapc_consts.svh"

module dapc_bus_swap #(
  parameter int W = `DAPC_DATA_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic select,
  input wire logic [W-1:0] word_a,
  input wire logic [W-1:0] word_b,
  output logic [W-1:0] bus_first,
  output logic [W-1:0] bus_second
);
  generate
    if (W < 1) begin : g_bad
      $error("bus width must be positive");
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (reset) begin
      bus_first <= '0;
      bus_second <= '0;
    end else begin
      bus_first <= select ? word_a : word_b;
      bus_second <= select ? word_b : word_a;
    end
  end

  AST_SWAP_HIGH: assert property (@(posedge clk) disable iff (reset)
    select |=> bus_first == $past(word_a) && bus_second == $past(word_b))
    else $error("select high mapping wrong");

  AST_SWAP_LOW: assert property (@(posedge clk) disable iff (reset)
    !select |=> bus_first == $past(word_b) && bus_second == $past(word_a))
    else $error("select low mapping wrong");
endmodule

// ===== hw/dapc_top.sv
// What this block does
// - Output enable high puts a channel's bus into high impedance; channel A's enable also releases the overflow.
// - Channel A and channel B each have their own output enable input.
// - Shutdown low keeps the channel converting normally.
// - Shutdown high with enable high sleeps the channel, reference off.
// - After sleep, data is invalid for milliseconds; receiver discards it.
// - Shutdown high with enable low naps the channel, reference kept on.
// - After nap, data valid after about 100 sample clocks.
// - Sleep or nap disables all outputs of that channel.
// - Each channel's power and enable follow only its own inputs, the common power down bit and the shared nap wake count.
// - Swap select high: channel A on first bus, B on second.
// - Swap select low: channel A on second bus, B on first.
// - Overflow flag disabled whenever channel A sleeps or naps.
// - Data ready clock disabled whenever channel B sleeps or naps.
`include "dapc_consts.svh"

module dapc_top #(
  parameter int SLEEP_CYCLES = `DAPC_SLEEP_WAKE_CYCLES,
  parameter int CNT_W = 20
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sample_clock_a,
  input wire logic sample_clock_b,
  input wire logic chan_a_power_down,
  input wire logic chan_b_power_down,
  input wire logic chan_a_output_enable_n,
  input wire logic chan_b_output_enable_n,
  input wire logic bus_swap_select,
  input wire logic [`DAPC_DATA_W-1:0] chan_a_result,
  input wire logic [`DAPC_DATA_W-1:0] chan_b_result,
  input wire logic chan_a_overrange,
  input wire logic chan_b_overrange,
  input wire logic [`DAPC_ADDR_W-1:0] reg_addr,
  input wire logic [`DAPC_REG_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [`DAPC_REG_W-1:0] reg_rdata,
  output logic [`DAPC_DATA_W-1:0] output_bus_first,
  output logic output_bus_first_oe,
  output logic [`DAPC_DATA_W-1:0] output_bus_second,
  output logic output_bus_second_oe,
  output logic overflow_flag,
  output logic overflow_flag_oe,
  output logic data_ready_clock,
  output logic data_ready_clock_oe
);
  generate
    if (CNT_W < 1 || CNT_W > 31) begin : g_bad
      $error("counter width out of range");
    end
  endgenerate

  logic clk_a_q;
  logic clk_b_q;
  logic tick_a;
  logic tick_b;
  logic power_down_request;
  logic [`DAPC_NAP_W-1:0] nap_wake;
  logic [`DAPC_DATA_W-1:0] held_a;
  logic [`DAPC_DATA_W-1:0] held_b;
  logic over_a;
  logic over_b;
  dapc_pkg::dapc_mode_e mode_a;
  dapc_pkg::dapc_mode_e mode_b;
  logic live_a;
  logic live_b;
  logic drive_a;
  logic drive_b;
  logic [`DAPC_REG_W-1:0] next_rdata;

  // sample clocks are synchronous levels here; a rising edge marks a sample
  always_ff @(posedge clk) begin
    if (reset) begin
      clk_a_q <= 1'b0;
      clk_b_q <= 1'b0;
    end else begin
      clk_a_q <= sample_clock_a;
      clk_b_q <= sample_clock_b;
    end
  end

  assign tick_a = sample_clock_a && !clk_a_q;
  assign tick_b = sample_clock_b && !clk_b_q;

  // each channel has its own controller, fed by its own pins plus the shared power down and nap wake registers
  dapc_chan_power #(
    .SLEEP_CYCLES(SLEEP_CYCLES),
    .CNT_W(CNT_W)
  ) u_power_a (
    .clk(clk),
    .reset(reset),
    .sample_tick(tick_a),
    .power_down(chan_a_power_down || power_down_request),
    .output_enable_n(chan_a_output_enable_n),
    .nap_cycles(nap_wake),
    .mode(mode_a),
    .live(live_a),
    .drive(drive_a)
  );

  dapc_chan_power #(
    .SLEEP_CYCLES(SLEEP_CYCLES),
    .CNT_W(CNT_W)
  ) u_power_b (
    .clk(clk),
    .reset(reset),
    .sample_tick(tick_b),
    .power_down(chan_b_power_down || power_down_request),
    .output_enable_n(chan_b_output_enable_n),
    .nap_cycles(nap_wake),
    .mode(mode_b),
    .live(live_b),
    .drive(drive_b)
  );

  // results are held per channel at its own sample edge
  always_ff @(posedge clk) begin
    if (reset) begin
      held_a <= '0;
      over_a <= 1'b0;
    end else if (tick_a) begin
      held_a <= chan_a_result;
      over_a <= chan_a_overrange;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      held_b <= '0;
      over_b <= 1'b0;
    end else if (tick_b) begin
      held_b <= chan_b_result;
      over_b <= chan_b_overrange;
    end
  end

  // swap select is taken every clock so that it can alternate per clock phase
  dapc_bus_swap #(
    .W(`DAPC_DATA_W)
  ) u_swap (
    .clk(clk),
    .reset(reset),
    .select(bus_swap_select),
    .word_a(held_a),
    .word_b(held_b),
    .bus_first(output_bus_first),
    .bus_second(output_bus_second)
  );

  // first bus pins belong to channel A's group, second to channel B's
  always_ff @(posedge clk) begin
    if (reset) begin
      output_bus_first_oe <= 1'b0;
      output_bus_second_oe <= 1'b0;
    end else begin
      output_bus_first_oe <= drive_a;
      output_bus_second_oe <= drive_b;
    end
  end

  // one shared overflow pin, owned by channel A's enable and power state
  always_ff @(posedge clk) begin
    if (reset) begin
      overflow_flag <= 1'b0;
      overflow_flag_oe <= 1'b0;
    end else begin
      overflow_flag <= over_a || over_b;
      overflow_flag_oe <= drive_a;
    end
  end

  // data ready clock is a two-cycle delayed copy of channel B's sample clock
  always_ff @(posedge clk) begin
    if (reset) begin
      data_ready_clock <= 1'b0;
      data_ready_clock_oe <= 1'b0;
    end else begin
      data_ready_clock <= clk_b_q;
      data_ready_clock_oe <= live_b;
    end
  end

  // control registers
  always_ff @(posedge clk) begin
    if (reset) begin
      power_down_request <= `DAPC_CTRL_RESET;
    end else if (reg_write && reg_addr == `DAPC_ADDR_CTRL) begin
      power_down_request <= reg_wdata[`DAPC_CTRL_PD_BIT];
    end
  end

  // a zero count is served as one sample clock
  always_ff @(posedge clk) begin
    if (reset) begin
      nap_wake <= `DAPC_NAP_WAKE_RESET;
    end else if (reg_write && reg_addr == `DAPC_ADDR_NAP_WAKE) begin
      nap_wake <= reg_wdata[`DAPC_NAP_W-1:0];
    end
  end

  always_comb begin
    next_rdata = '0;
    if (reg_read) begin
      unique case (reg_addr)
        `DAPC_ADDR_CTRL: next_rdata[`DAPC_CTRL_PD_BIT] = power_down_request;
        `DAPC_ADDR_NAP_WAKE: next_rdata[`DAPC_NAP_W-1:0] = nap_wake;
        `DAPC_ADDR_STATUS: begin
          next_rdata[`DAPC_STAT_MODE_A_LSB +: `DAPC_MODE_W] = mode_a;
          next_rdata[`DAPC_STAT_MODE_B_LSB +: `DAPC_MODE_W] = mode_b;
          next_rdata[`DAPC_STAT_LIVE_A_BIT] = live_a;
          next_rdata[`DAPC_STAT_LIVE_B_BIT] = live_b;
        end
        default: next_rdata = '0;
      endcase
    end
  end

  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) reg_rdata <= '0;
    else reg_rdata <= next_rdata;
  end

  AST_OE_FIRST: assert property (@(posedge clk) disable iff (reset)
    chan_a_output_enable_n && tick_a |=> ##1 !output_bus_first_oe && !overflow_flag_oe)
    else $error("channel a outputs not released");

  AST_OE_SECOND: assert property (@(posedge clk) disable iff (reset)
    chan_b_output_enable_n && tick_b |=> ##1 !output_bus_second_oe)
    else $error("channel b outputs not released");

  AST_OVERFLOW_OFF: assert property (@(posedge clk) disable iff (reset)
    (mode_a == dapc_pkg::DAPC_NAP || mode_a == dapc_pkg::DAPC_SLEEP)
    |=> !overflow_flag_oe)
    else $error("overflow driven while channel a is down");

  AST_READY_CLOCK_OFF: assert property (@(posedge clk) disable iff (reset)
    !live_b |=> !data_ready_clock_oe)
    else $error("data ready clock driven while channel b is down");

  AST_READY_CLOCK_COPY: assert property (@(posedge clk) disable iff (reset)
    sample_clock_b |=> ##1 data_ready_clock)
    else $error("data ready clock does not follow channel b");

  AST_RECOVER_QUIET: assert property (@(posedge clk) disable iff (reset)
    !live_a ##1 !live_a |-> !output_bus_first_oe)
    else $error("first bus driven before recovery ends");

  AST_READ_ONE_CYCLE: assert property (@(posedge clk) disable iff (reset)
    !reg_read |=> reg_rdata == '0)
    else $error("read data outside its cycle");

  // a sample edge with enable low and no shutdown keeps the group driven
  AST_OE_FIRST_ON: assert property (@(posedge clk) disable iff (reset)
    tick_a && live_a && !chan_a_output_enable_n && !chan_a_power_down && !power_down_request
    |=> ##1 output_bus_first_oe && overflow_flag_oe)
    else $error("channel a outputs not driven while running");

  AST_OE_SECOND_ON: assert property (@(posedge clk) disable iff (reset)
    tick_b && live_b && !chan_b_output_enable_n && !chan_b_power_down && !power_down_request
    |=> ##1 output_bus_second_oe && data_ready_clock_oe)
    else $error("channel b outputs not driven while running");

  AST_SECOND_QUIET: assert property (@(posedge clk) disable iff (reset)
    !live_b |=> !output_bus_second_oe)
    else $error("second bus driven while channel b is down");

  AST_READY_CLOCK_ON: assert property (@(posedge clk) disable iff (reset)
    live_b |=> data_ready_clock_oe)
    else $error("data ready clock not driven while channel b runs");

  AST_COMMON_POWER_DOWN: assert property (@(posedge clk) disable iff (reset)
    tick_a && live_a && power_down_request |=> ##1 !live_a)
    else $error("common power down not taken by channel a");

  // both channels share the overflow pin, so either overrange sets it
  AST_OVERFLOW_OR: assert property (@(posedge clk) disable iff (reset)
    tick_a && tick_b |=> ##1 overflow_flag == $past(chan_a_overrange || chan_b_overrange, 2))
    else $error("overflow flag does not follow overrange");

  // latch edge, select taken a cycle later, bus shown a cycle after that
  AST_FIRST_FROM_A: assert property (@(posedge clk) disable iff (reset)
    tick_a ##1 bus_swap_select |=> output_bus_first == $past(chan_a_result, 2))
    else $error("first bus does not carry channel a");

  AST_SECOND_FROM_B: assert property (@(posedge clk) disable iff (reset)
    tick_b ##1 bus_swap_select |=> output_bus_second == $past(chan_b_result, 2))
    else $error("second bus does not carry channel b");

  AST_FIRST_FROM_B: assert property (@(posedge clk) disable iff (reset)
    tick_b ##1 !bus_swap_select |=> output_bus_first == $past(chan_b_result, 2))
    else $error("first bus does not carry channel b when swapped");

  AST_SECOND_FROM_A: assert property (@(posedge clk) disable iff (reset)
    tick_a ##1 !bus_swap_select |=> output_bus_second == $past(chan_a_result, 2))
    else $error("second bus does not carry channel a when swapped");

  // held words move only at their own sample edge
  AST_HELD_A_STEADY: assert property (@(posedge clk) disable iff (reset)
    !tick_a |=> held_a == $past(held_a))
    else $error("channel a word changed between sample edges");

  AST_HELD_B_STEADY: assert property (@(posedge clk) disable iff (reset)
    !tick_b |=> held_b == $past(held_b))
    else $error("channel b word changed between sample edges");

  AST_CTRL_WRITE: assert property (@(posedge clk) disable iff (reset)
    reg_write && reg_addr == `DAPC_ADDR_CTRL
    |=> power_down_request == $past(reg_wdata[`DAPC_CTRL_PD_BIT]))
    else $error("control write not taken");

  AST_NAP_WAKE_WRITE: assert property (@(posedge clk) disable iff (reset)
    reg_write && reg_addr == `DAPC_ADDR_NAP_WAKE
    |=> nap_wake == $past(reg_wdata[`DAPC_NAP_W-1:0]))
    else $error("nap wake write not taken");

  AST_CTRL_READ: assert property (@(posedge clk) disable iff (reset)
    reg_read && reg_addr == `DAPC_ADDR_CTRL
    |=> reg_rdata[`DAPC_CTRL_PD_BIT] == $past(power_down_request))
    else $error("control read wrong");

  AST_NAP_WAKE_READ: assert property (@(posedge clk) disable iff (reset)
    reg_read && reg_addr == `DAPC_ADDR_NAP_WAKE
    |=> reg_rdata[`DAPC_NAP_W-1:0] == $past(nap_wake))
    else $error("nap wake read wrong");

  AST_STATUS_LIVE: assert property (@(posedge clk) disable iff (reset)
    reg_read && reg_addr == `DAPC_ADDR_STATUS
    |=> reg_rdata[`DAPC_STAT_LIVE_A_BIT] == $past(live_a)
      && reg_rdata[`DAPC_STAT_LIVE_B_BIT] == $past(live_b))
    else $error("status live bits wrong");

  AST_STATUS_MODES: assert property (@(posedge clk) disable iff (reset)
    reg_read && reg_addr == `DAPC_ADDR_STATUS
    |=> reg_rdata[`DAPC_STAT_MODE_A_LSB +: `DAPC_MODE_W] == $past(mode_a)
      && reg_rdata[`DAPC_STAT_MODE_B_LSB +: `DAPC_MODE_W] == $past(mode_b))
    else $error("status mode fields wrong");

  AST_READ_UNMAPPED: assert property (@(posedge clk) disable iff (reset)
    reg_read && reg_addr != `DAPC_ADDR_CTRL && reg_addr != `DAPC_ADDR_NAP_WAKE
    && reg_addr != `DAPC_ADDR_STATUS |=> reg_rdata == '0)
    else $error("unmapped read not zero");
endmodule

// ===== dv/dapc_rx_model.sv
`include "dapc_consts.svh"

module dapc_rx_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic bus_first_oe,
  input wire logic [`DAPC_DATA_W-1:0] bus_first,
  output logic sample_clock_a,
  output logic sample_clock_b,
  output logic [15:0] rx_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase;
  logic shared_clock;
  logic shared_q;
  logic [`DAPC_DATA_W-1:0] rx_word;

  always_ff @(posedge clk) begin
    if (reset) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end
  // clk/4 gives 62.5 Msps, inside the shared-bus limit
  assign shared_clock = phase[1];
  // both sample clocks come from one source
  assign sample_clock_a = shared_clock;
  assign sample_clock_b = shared_clock;

  // only the first bus is read; words while outputs are off are dropped
  always_ff @(posedge clk) begin
    shared_q <= shared_clock;
    if (reset) begin
      rx_count <= 16'h0;
      rx_word <= '0;
    end else if (shared_clock && !shared_q && bus_first_oe) begin
      rx_count <= rx_count + 16'h1;
      rx_word <= bus_first;
    end
  end
endmodule

// ===== dv/dapc_top_test.sv
`include "dapc_consts.svh"

module dapc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    bit is_rd;
    logic [31:0] rdata;
    logic [3:0] oes;
    logic [13:0] bf;
    logic [13:0] bs;
    logic of;
  } dapc_note_s;

  logic clk = 1'b0;
  logic reset = 1'b1;
  logic pd_a = 1'b0, pd_b = 1'b0, oen_a = 1'b0, oen_b = 1'b0, sel = 1'b1;
  logic [13:0] wa = 14'h0, wb = 14'h0;
  logic ova = 1'b0, ovb = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0, reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic [13:0] bus_first, bus_second;
  logic bus_first_oe, bus_second_oe, of_flag, of_oe, rdy_clk, rdy_oe, sca, scb;
  logic [15:0] rx_count;
  logic probe = 1'b0, rd_seen = 1'b0;
  logic [1:0] scb_hist = 2'h0;
  dapc_note_s notes[$];
  int n_mismatch = 0;
  int checked = 0;

  always #2 clk = ~clk;

  dapc_top #(.SLEEP_CYCLES(50), .CNT_W(20)) DUT (
    .clk(clk), .reset(reset), .sample_clock_a(sca), .sample_clock_b(scb),
    .chan_a_power_down(pd_a), .chan_b_power_down(pd_b),
    .chan_a_output_enable_n(oen_a), .chan_b_output_enable_n(oen_b),
    .bus_swap_select(sel), .chan_a_result(wa), .chan_b_result(wb),
    .chan_a_overrange(ova), .chan_b_overrange(ovb), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .output_bus_first(bus_first),
    .output_bus_first_oe(bus_first_oe), .output_bus_second(bus_second),
    .output_bus_second_oe(bus_second_oe), .overflow_flag(of_flag),
    .overflow_flag_oe(of_oe), .data_ready_clock(rdy_clk), .data_ready_clock_oe(rdy_oe)
  );

  dapc_rx_model rx (
    .clk(clk), .reset(reset), .bus_first_oe(bus_first_oe), .bus_first(bus_first),
    .sample_clock_a(sca), .sample_clock_b(scb), .rx_count(rx_count)
  );

  always @(posedge clk) rd_seen <= reg_read;
  // ready clock should be channel b's sample clock two core clocks late
  always @(posedge clk) scb_hist <= {scb_hist[0], scb};

  always @(negedge clk) begin
    dapc_note_s n;
    if (probe === 1'b1 || rd_seen === 1'b1) begin
      if (notes.size() == 0) begin
        n_mismatch++;
        $display("wrong value at %0t: result with no note", $time);
      end else begin
        n = notes.pop_front();
        checked++;
        if (n.is_rd && reg_rdata !== n.rdata) begin
          n_mismatch++;
          $display("wrong value at %0t: read %h expected %h", $time, reg_rdata, n.rdata);
        end
        if (!n.is_rd && ({bus_first_oe, bus_second_oe, of_oe, rdy_oe} !== n.oes
            || bus_first !== n.bf || bus_second !== n.bs || of_flag !== n.of)) begin
          n_mismatch++;
          $display("wrong value at %0t: oe %b%b%b%b expected %b", $time, bus_first_oe,
                   bus_second_oe, of_oe, rdy_oe, n.oes);
        end
        if (!n.is_rd && rdy_clk !== scb_hist[1]) begin
          n_mismatch++;
          $display("wrong value at %0t: ready clock %b expected %b", $time, rdy_clk,
                   scb_hist[1]);
        end
      end
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
    notes.push_back('{1'b1, e, 4'h0, 14'h0, 14'h0, 1'b0});
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic probe_out(input logic [3:0] oes);
    notes.push_back('{1'b0, 32'h0, oes, sel ? wa : wb, sel ? wb : wa, ova | ovb});
    probe <= 1'b1;
    @(posedge clk);
    probe <= 1'b0;
    @(posedge clk);
  endtask

  // pin order: pd_a, oen_a, pd_b, oen_b; then ten core clocks pass before the next step
  task automatic set_pins(input logic [3:0] v);
    {pd_a, oen_a, pd_b, oen_b} <= v;
    tick(10);
  endtask

  task automatic wake(input logic [3:0] v, input int lo, input int hi,
                      input logic [3:0] oes_lo, input logic [3:0] oes_hi);
    {pd_a, oen_a, pd_b, oen_b} <= v;
    tick(lo);
    probe_out(oes_lo);
    tick(hi - lo - 2);
    probe_out(oes_hi);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(20000 * 4);
    n_mismatch++;
    $display("wrong value at %0t: run timed out", $time);
    report_and_stop();
  end

  initial begin
    void'($urandom(32'h477f));
    tick(5);
    reset <= 1'b0;
    tick(10);
    reg_rd(4'h4, 32'h64);
    reg_rd(4'h0, 32'h0);
    reg_rd(4'h8, 32'hc0);
    reg_rd(4'hc, 32'h0);
    reg_wr(4'h8, 32'hff);
    reg_rd(4'h8, 32'hc0);
    done("registers");
    for (int i = 0; i < 8; i++) begin
      wa <= 14'($urandom());
      wb <= 14'($urandom());
      ova <= 1'($urandom());
      ovb <= 1'($urandom());
      sel <= i[0];
      tick(10);
      probe_out(4'hf);
    end
    done("data and swap");
    set_pins(4'b0100);
    probe_out(4'b0101);
    set_pins(4'b0001);
    probe_out(4'b1011);
    done("output enable");
    set_pins(4'b1000);
    probe_out(4'b0101);
    reg_rd(4'h8, 32'h81);
    set_pins(4'b1100);
    probe_out(4'b0101);
    reg_rd(4'h8, 32'h82);
    wake(4'b0000, 40, 70, 4'b0101, 4'b1111);
    done("channel a sleep and nap");
    set_pins(4'b0010);
    probe_out(4'b1010);
    reg_rd(4'h8, 32'h48);
    wake(4'b0000, 380, 430, 4'b1010, 4'b1111);
    reg_wr(4'h4, 32'h4);
    reg_rd(4'h4, 32'h4);
    set_pins(4'b0010);
    wake(4'b0000, 6, 30, 4'b1010, 4'b1111);
    done("channel b nap wake");
    reg_wr(4'h0, 32'h1);
    tick(10);
    probe_out(4'b0000);
    reg_rd(4'h8, 32'h09);
    reg_wr(4'h0, 32'h0);
    tick(40);
    probe_out(4'hf);
    done("common power down");
    // a pulse that falls between sample edges must not be seen
    @(posedge sca);
    tick(1);
    pd_a <= 1'b1;
    tick(1);
    pd_a <= 1'b0;
    tick(10);
    probe_out(4'hf);
    done("pin sampling");
    checked++;
    if (rx_count == 16'h0) begin
      n_mismatch++;
      $display("wrong value at %0t: receiver took no words", $time);
    end
    report_and_stop();
  end
endmodule
